/* rtl/lmb_defines.svh */
// constants for the local memory bus master controller
// How it works
// - upper strobe even byte, lower odd byte
// - word accesses ride on data lines 0-15
// - all do byte and word; 32-bit optional
// - master does single cycles at least
// - odd byte lines 0-7, even 8-15
// - longword uses all 32 lines, same lanes
// - indivisible multi cycle excludes other masters
// - six basic cycle types, any width
// - master timer ends unanswered cycles
// - master may withdraw after lower address
// - multiplexed address with lower, upper strobes
`ifndef LMB_DEFINES_SVH
`define LMB_DEFINES_SVH
`define LMB_TIMEOUT_NS 10000
`define LMB_CLK_NS 10
`define LMB_SETUP_CYC 4'h2
`define LMB_ADDR_W 24
`define LMB_LOW_W 12
`define LMB_HIGH_LSB 12
`define LMB_LW_BIT 0
`define LMB_BYTE_BIT 0
`define LMB_WORD_BIT 1
`define LMB_CNT_W 16
`endif

/* rtl/lmb_pkg.sv */
// types for the local memory bus master controller
package lmb_pkg;
  typedef enum logic [1:0] {LMB_BYTE = 2'h0, LMB_WORD = 2'h1, LMB_LONG = 2'h2} lmb_width_t;
  typedef enum logic [2:0] {
    LMB_SGL_WR = 3'h0, LMB_SGL_RD = 3'h1, LMB_SEQ_WR = 3'h2, LMB_SEQ_RD = 3'h3,
    LMB_ISA = 3'h4, LMB_IMA = 3'h5
  } lmb_cyc_t;
  typedef enum logic [2:0] {
    LMB_OK = 3'h0, LMB_ABORT = 3'h1, LMB_LATE = 3'h2, LMB_TIMEOUT = 3'h3,
    LMB_WITHDRAWN = 3'h4
  } lmb_result_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_LOWADR = 3'h1, ST_DECIDE = 3'h2, ST_UPADR = 3'h3,
    ST_STROBE = 3'h4, ST_RELEASE = 3'h5, ST_DONE = 3'h6
  } lmb_state_t;
  // user command
  typedef struct packed {
    lmb_cyc_t cyc;
    lmb_width_t width;
    logic [23:0] addr;
    logic [31:0] wdata;
    logic rmw_write; // second access of an indivisible cycle writes
  } lmb_req_t;
  // bus pins driven by the master
  typedef struct packed {
    logic [22:0] adr;
    logic adr_oe;
    logic lower_addr_strobe;
    logic upper_addr_strobe_n;
    logic upper_byte_strobe_n;
    logic lower_byte_strobe_n;
    logic read;
    logic lock_n;
    logic [31:0] dat;
    logic dat_oe;
  } lmb_pins_t;
  // module state
  typedef struct packed {
    lmb_state_t st;
    lmb_req_t req;
    lmb_pins_t pins;
    logic [15:0] tmr;
    logic [3:0] wait_cnt;
    logic second;
    logic [31:0] rdata;
    lmb_result_t result;
    logic done;
  } lmb_state_s_t;
endpackage

/* rtl/lmb_master.sv */
// master controller that drives the local memory expansion bus
`timescale 1ns/100ps
`include "lmb_defines.svh"
module lmb_master
  import lmb_pkg::*;
#(
  parameter int TIMEOUT_CYC = (`LMB_TIMEOUT_NS) / (`LMB_CLK_NS)
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire lmb_req_t req_i,
  input wire logic on_bus_i,
  input wire logic on_bus_valid_i,
  input wire logic seq_more_i,
  output logic done_o,
  output lmb_result_t result_o,
  output logic [31:0] rdata_o,
  output lmb_pins_t pins_o,
  input wire logic [31:0] dat_i,
  input wire logic ack_n_i,
  input wire logic transfer_error_line_n_i
);
  lmb_state_s_t s_q, s_d;
  logic ack_seen, err_seen;
  logic [15:0] tmo_lim;
  assign tmo_lim = 16'(TIMEOUT_CYC);
  assign ack_seen = !ack_n_i;
  assign err_seen = !transfer_error_line_n_i;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      ST_IDLE:
      begin
        s_d.pins.adr_oe = 1'b0;
        s_d.pins.dat_oe = 1'b0;
        s_d.pins.lock_n = 1'b1;
        if (req_valid_i)
        begin
          s_d.req = req_i;
          s_d.second = 1'b0;
          s_d.st = ST_LOWADR;
        end
      end
      ST_LOWADR:
      begin
        // lower address first, longword select rides on the low line
        s_d.pins.adr = {11'h000, s_q.req.addr[`LMB_LOW_W-1:1],
          s_q.req.width == LMB_LONG};
        s_d.pins.adr_oe = 1'b1;
        s_d.pins.lower_addr_strobe = 1'b1;
        s_d.pins.read = (s_q.req.cyc == LMB_SGL_RD) || (s_q.req.cyc == LMB_SEQ_RD)
          || (s_q.req.cyc == LMB_ISA) || (s_q.req.cyc == LMB_IMA);
        s_d.pins.lock_n = !(s_q.req.cyc == LMB_ISA || s_q.req.cyc == LMB_IMA);
        s_d.wait_cnt = `LMB_SETUP_CYC;
        s_d.st = ST_DECIDE;
      end
      ST_DECIDE:
      begin
        if (s_q.wait_cnt != 4'h0)
          s_d.wait_cnt = s_q.wait_cnt - 4'h1;
        else if (on_bus_valid_i && !on_bus_i)
        begin
          // not for this bus: stop after the lower address
          s_d.result = LMB_WITHDRAWN;
          s_d.st = ST_RELEASE;
        end
        else if (on_bus_valid_i)
        begin
          s_d.pins.adr = {s_q.req.addr[`LMB_ADDR_W-1:`LMB_HIGH_LSB], 11'h000};
          s_d.pins.upper_addr_strobe_n = 1'b0;
          s_d.st = ST_UPADR;
        end
      end
      ST_UPADR:
      begin
        // byte strobes give the last address bit
        s_d.pins.upper_byte_strobe_n = !(s_q.req.width != LMB_BYTE
          || !s_q.req.addr[`LMB_BYTE_BIT]);
        s_d.pins.lower_byte_strobe_n = !(s_q.req.width != LMB_BYTE
          || s_q.req.addr[`LMB_BYTE_BIT]);
        if (!s_q.pins.read)
        begin
          s_d.pins.dat_oe = 1'b1;
          case (s_q.req.width)
            LMB_LONG: s_d.pins.dat = s_q.req.wdata;
            LMB_WORD: s_d.pins.dat = {16'h0000, s_q.req.wdata[15:0]};
            default: s_d.pins.dat = {16'h0000, s_q.req.wdata[7:0], s_q.req.wdata[7:0]};
          endcase
        end
        s_d.tmr = 16'h0000;
        s_d.st = ST_STROBE;
      end
      ST_STROBE:
      begin
        s_d.tmr = s_q.tmr + 16'h0001;
        if (err_seen)
        begin
          s_d.result = s_q.second ? LMB_LATE : LMB_ABORT;
          s_d.st = ST_RELEASE;
        end
        else if (ack_seen)
        begin
          // capture read data in lane order; a write keeps the last read data,
          // so the read half of an indivisible cycle survives its write-back
          if (s_q.pins.read)
          begin
            case (s_q.req.width)
              LMB_LONG: s_d.rdata = dat_i;
              LMB_WORD: s_d.rdata = {16'h0000, dat_i[15:0]};
              default: s_d.rdata = {24'h000000, s_q.req.addr[`LMB_BYTE_BIT] ?
                dat_i[7:0] : dat_i[15:8]};
            endcase
          end
          s_d.result = LMB_OK;
          s_d.st = ST_RELEASE;
        end
        else if (s_q.tmr >= tmo_lim)
        begin
          s_d.result = LMB_TIMEOUT;
          s_d.st = ST_RELEASE;
        end
      end
      ST_RELEASE:
      begin
        // drop data strobes; slave then frees acknowledge
        s_d.pins.upper_byte_strobe_n = 1'b1;
        s_d.pins.lower_byte_strobe_n = 1'b1;
        s_d.pins.dat_oe = 1'b0;
        if (ack_n_i && transfer_error_line_n_i)
        begin
          if (s_q.result == LMB_OK && !s_q.second && (s_q.req.cyc == LMB_ISA ||
            s_q.req.cyc == LMB_IMA || ((s_q.req.cyc == LMB_SEQ_RD ||
            s_q.req.cyc == LMB_SEQ_WR) && seq_more_i)))
          begin
            // follow-on access; indivisible ones get one more, a write only if rmw_write is set
            s_d.second = (s_q.req.cyc == LMB_ISA || s_q.req.cyc == LMB_IMA);
            s_d.pins.read = !(s_q.req.cyc == LMB_ISA || s_q.req.cyc == LMB_IMA)
              ? s_q.pins.read : !s_q.req.rmw_write;
            if (s_q.req.cyc == LMB_IMA)
              s_d.req.addr = s_q.req.addr + 24'h000002;
            s_d.st = ST_UPADR;
          end
          else
            s_d.st = ST_DONE;
        end
      end
      ST_DONE:
      begin
        s_d.pins.lower_addr_strobe = 1'b0;
        s_d.pins.upper_addr_strobe_n = 1'b1;
        s_d.pins.lock_n = 1'b1;
        s_d.pins.adr_oe = 1'b0;
        s_d.done = 1'b1;
        s_d.st = ST_IDLE;
      end
      default: s_d.st = ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      s_q <= '0;
      s_q.st <= ST_IDLE;
      s_q.pins.upper_addr_strobe_n <= 1'b1;
      s_q.pins.upper_byte_strobe_n <= 1'b1;
      s_q.pins.lower_byte_strobe_n <= 1'b1;
      s_q.pins.lock_n <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  assign req_ready_o = (s_q.st == ST_IDLE);
  assign done_o = s_q.done;
  assign result_o = s_q.result;
  assign rdata_o = s_q.rdata;
  assign pins_o = s_q.pins;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  timeout_bound_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (s_q.st == ST_STROBE && ack_n_i && transfer_error_line_n_i && s_q.tmr >= tmo_lim)
    |=> s_q.st == ST_RELEASE && s_q.result == LMB_TIMEOUT)
    else $error("timeout not taken");
  withdraw_no_upper_a: assert property (@(posedge clk_i) disable iff (reset_i)
    (s_q.st == ST_DECIDE && s_q.wait_cnt == 4'h0 && on_bus_valid_i && !on_bus_i)
    |=> s_q.pins.upper_addr_strobe_n ##1 s_q.pins.upper_addr_strobe_n)
    else $error("withdrawn cycle sent upper address");
  byte_lane_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !(s_q.pins.upper_byte_strobe_n) && s_q.req.width == LMB_BYTE
    |-> !s_q.req.addr[0] && s_q.pins.lower_byte_strobe_n)
    else $error("even byte strobe on odd address");
  word_lanes_a: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.pins.dat_oe && s_q.req.width == LMB_WORD |-> s_q.pins.dat[31:16] == 16'h0000)
    else $error("word data off low lines");
  strobes_hold_a: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.st == ST_STROBE && !ack_seen && !err_seen && s_q.tmr < tmo_lim
    |=> $stable(s_q.pins.upper_byte_strobe_n) && $stable(s_q.pins.lower_byte_strobe_n))
    else $error("strobes dropped before answer");
  single_done_a: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.st == ST_RELEASE && ack_n_i && transfer_error_line_n_i && s_q.req.cyc == LMB_SGL_RD
    |=> ##1 done_o)
    else $error("single cycle did not finish");
  lock_held_a: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.st == ST_STROBE && s_q.req.cyc == LMB_IMA |-> !s_q.pins.lock_n)
    else $error("lock missing in indivisible cycle");
  error_result_a: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.st == ST_STROBE && err_seen |=> s_q.result != LMB_OK)
    else $error("error answer reported as success");
  cov_read_c: cover property (@(posedge clk_i) done_o && result_o == LMB_OK);
  cov_tmo_c: cover property (@(posedge clk_i) done_o && result_o == LMB_TIMEOUT);
  cov_wd_c: cover property (@(posedge clk_i) done_o && result_o == LMB_WITHDRAWN);
  cov_late_c: cover property (@(posedge clk_i) done_o && result_o == LMB_LATE);
  // longword writes fill all 32 data lines
  long_lanes_a: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.pins.dat_oe && s_q.req.width == LMB_LONG |-> s_q.pins.dat == s_q.req.wdata)
    else $error("longword data not on all lines");
  // a byte write shows the byte on both lanes so either strobe picks it up
  byte_copy_a: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.pins.dat_oe && s_q.req.width == LMB_BYTE
    |-> s_q.pins.dat[15:8] == s_q.req.wdata[7:0] && s_q.pins.dat[7:0] == s_q.req.wdata[7:0])
    else $error("byte data off its lanes");
  // upper address only ever rides under a standing lower address
  upper_after_lower_a: assert property (@(posedge clk_i) disable iff (reset_i)
    !s_q.pins.upper_addr_strobe_n |-> s_q.pins.lower_addr_strobe)
    else $error("upper address without lower address");
  // word and longword accesses select both byte lanes
  word_strobes_a: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.st == ST_STROBE && s_q.req.width != LMB_BYTE
    |-> !s_q.pins.upper_byte_strobe_n && !s_q.pins.lower_byte_strobe_n)
    else $error("word access missing a byte strobe");
  // indivisible cycles keep other masters out while data moves
  isa_lock_a: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.st == ST_STROBE && s_q.req.cyc == LMB_ISA |-> !s_q.pins.lock_n)
    else $error("lock missing in single address cycle");
  lock_free_a: assert property (@(posedge clk_i) disable iff (reset_i)
    done_o |-> s_q.pins.lock_n)
    else $error("lock left on after cycle end");
  // data strobes come off one cycle into release so the slave can free its answer
  strobes_off_a: assert property (@(posedge clk_i) disable iff (reset_i)
    s_q.st == ST_RELEASE |=> s_q.pins.upper_byte_strobe_n && s_q.pins.lower_byte_strobe_n)
    else $error("data strobes held past release");
endmodule

/* bench/lmb_slave_model.sv */
// memory board model answering the local memory bus
`timescale 1ns/100ps
module lmb_slave_model
  import lmb_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire lmb_pins_t pins_i,
  input wire logic d32_i,
  input wire logic mute_i,
  input wire logic perr_i,
  input wire logic [3:0] dly_i,
  output logic [31:0] dat_o,
  output logic ack_n_o,
  output logic transfer_error_line_n_o
);
  logic [15:0] mem [0:127];
  logic [6:0] wa;
  logic lw;
  logic [3:0] cnt;
  logic [31:0] rd;
  logic strb;
  assign strb = !pins_i.upper_byte_strobe_n || !pins_i.lower_byte_strobe_n;
  // read data only while acknowledged, an inverted pattern otherwise
  assign dat_o = (!ack_n_o && pins_i.read) ? rd : ~rd;
  // address latch, handshake and array access
  always_ff @(posedge clk_i)
  begin
    if (pins_i.lower_addr_strobe && pins_i.upper_addr_strobe_n)
    begin
      wa <= pins_i.adr[7:1];
      lw <= pins_i.adr[0];
    end
    if (reset_i)
      rd <= 32'h0;
    if (reset_i || !strb)
    begin
      cnt <= 4'h0;
      ack_n_o <= 1'b1;
      transfer_error_line_n_o <= 1'b1;
    end
    else if (ack_n_o && transfer_error_line_n_o && !mute_i)
    begin
      if (cnt != dly_i)
        cnt <= cnt + 4'h1;
      else if ((lw && !d32_i) || (perr_i && !pins_i.read))
        transfer_error_line_n_o <= 1'b0;
      else
      begin
        ack_n_o <= 1'b0;
        rd <= lw ? {mem[wa], mem[wa + 7'h1]} : {16'h0, mem[wa]};
        if (!pins_i.read && lw)
        begin
          mem[wa] <= pins_i.dat[31:16];
          mem[wa + 7'h1] <= pins_i.dat[15:0];
        end
        if (!pins_i.read && !lw && !pins_i.upper_byte_strobe_n)
          mem[wa][15:8] <= pins_i.dat[15:8];
        if (!pins_i.read && !lw && !pins_i.lower_byte_strobe_n)
          mem[wa][7:0] <= pins_i.dat[7:0];
        if (pins_i.lock_n)
          wa <= wa + (lw ? 7'h2 : 7'h1);
      end
    end
  end
endmodule

/* bench/tb.sv */
// self-checking bench for the local memory bus master
`timescale 1ns/100ps
module tb;
  import lmb_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  logic req_ready;
  lmb_req_t req = '0;
  logic on_bus = 1'b1;
  logic done;
  lmb_result_t result;
  logic [31:0] rdata;
  lmb_pins_t pins;
  logic [31:0] dat;
  logic ack_n;
  logic transfer_error_line_n;
  logic d32 = 1'b1;
  logic mute = 1'b0;
  logic perr = 1'b0;
  logic [3:0] dly = 4'h1;
  logic seq_more = 1'b0;
  int n_errors = 0;
  int checks_done = 0;
  lmb_master #(.TIMEOUT_CYC(20)) u_dut (.clk_i(clk), .reset_i(reset), .req_valid_i(req_valid),
    .req_ready_o(req_ready), .req_i(req), .on_bus_i(on_bus), .on_bus_valid_i(1'b1),
    .seq_more_i(seq_more), .done_o(done), .result_o(result), .rdata_o(rdata), .pins_o(pins),
    .dat_i(dat), .ack_n_i(ack_n), .transfer_error_line_n_i(transfer_error_line_n));
  lmb_slave_model u_slv (.clk_i(clk), .reset_i(reset), .pins_i(pins), .d32_i(d32),
    .mute_i(mute), .perr_i(perr), .dly_i(dly), .dat_o(dat), .ack_n_o(ack_n),
    .transfer_error_line_n_o(transfer_error_line_n));
  // clock
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (n_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one request, held until taken, then wait for completion
  task automatic xfer(input lmb_cyc_t c, input lmb_width_t w, input logic [23:0] a,
    input logic [31:0] d, input logic rmw, input logic ob, input lmb_result_t exp);
    int n;
    n = 0;
    @(negedge clk);
    req = '{c, w, a, d, rmw};
    on_bus = ob;
    req_valid = 1'b1;
    // ready is looked at between edges, where it has settled
    while (req_ready !== 1'b1)
      @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    while (done !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    check({31'h0, done}, 32'h1);
    check({29'h0, result}, {29'h0, exp});
  endtask
  task automatic t_lanes();
    xfer(LMB_SGL_WR, LMB_LONG, 24'h000010, 32'h11223344, 1'b0, 1'b1, LMB_OK);
    xfer(LMB_SGL_RD, LMB_WORD, 24'h000010, 32'h0, 1'b0, 1'b1, LMB_OK);
    check(rdata, 32'h00001122);
    xfer(LMB_SGL_RD, LMB_WORD, 24'h000012, 32'h0, 1'b0, 1'b1, LMB_OK);
    check(rdata, 32'h00003344);
    xfer(LMB_SGL_WR, LMB_BYTE, 24'h000013, 32'h00005A5A, 1'b0, 1'b1, LMB_OK);
    xfer(LMB_SGL_RD, LMB_BYTE, 24'h000011, 32'h0, 1'b0, 1'b1, LMB_OK);
    check(rdata, 32'h00000022);
    xfer(LMB_SGL_RD, LMB_BYTE, 24'h000012, 32'h0, 1'b0, 1'b1, LMB_OK);
    check(rdata, 32'h00000033);
    xfer(LMB_SGL_RD, LMB_LONG, 24'h000010, 32'h0, 1'b0, 1'b1, LMB_OK);
    check(rdata, 32'h1122335A);
  endtask
  task automatic t_faults();
    d32 = 1'b0;
    xfer(LMB_SGL_RD, LMB_LONG, 24'h000010, 32'h0, 1'b0, 1'b1, LMB_ABORT);
    d32 = 1'b1;
    mute = 1'b1;
    xfer(LMB_SGL_RD, LMB_WORD, 24'h000020, 32'h0, 1'b0, 1'b1, LMB_TIMEOUT);
    check({31'h0, pins.upper_byte_strobe_n}, 32'h1);
    mute = 1'b0;
    xfer(LMB_SGL_WR, LMB_WORD, 24'h000030, 32'h0, 1'b0, 1'b0, LMB_WITHDRAWN);
  endtask
  task automatic t_indivisible();
    perr = 1'b1;
    xfer(LMB_ISA, LMB_WORD, 24'h000010, 32'h0000BEEF, 1'b1, 1'b1, LMB_LATE);
    perr = 1'b0;
    dly = 4'h6;
    xfer(LMB_ISA, LMB_WORD, 24'h000010, 32'h0000BEEF, 1'b1, 1'b1, LMB_OK);
    check(rdata, 32'h00001122);
    dly = 4'h0;
    xfer(LMB_SGL_RD, LMB_WORD, 24'h000010, 32'h0, 1'b0, 1'b1, LMB_OK);
    check(rdata, 32'h0000BEEF);
    xfer(LMB_IMA, LMB_WORD, 24'h000010, 32'h0, 1'b0, 1'b1, LMB_OK);
  endtask
  // sequential read: two words behind one address phase, the slave counts on
  task automatic t_seq();
    seq_more = 1'b1;
    fork
      xfer(LMB_SEQ_RD, LMB_WORD, 24'h000010, 32'h0, 1'b0, 1'b1, LMB_OK);
      begin
        @(negedge ack_n);
        @(negedge ack_n);
        @(negedge clk);
        seq_more = 1'b0;
      end
    join
    check(rdata, 32'h0000335A);
  endtask
  // watchdog
  initial
  begin
    #50000;
    n_errors++;
    test_done();
  end
  // main sequence
  initial
  begin
    repeat (4) @(negedge clk);
    reset = 1'b0;
    t_lanes();
    t_faults();
    t_indivisible();
    t_seq();
    test_done();
  end
endmodule
